// *** rtl/piopb_pkg.sv ***
// Package for the parallel I/O port bank: register map, reset values, per-pin modes.
// Assumes an 8-bit CPU register port with byte addresses 0x00..0x11.
package piopb_pkg;
  localparam int PIOPB_PORTS = 6;
  localparam int PIOPB_WIDTH = 8;
  localparam int PIOPB_AW = 5;
  localparam logic [4:0] PORT_A_DATA = 5'h00;
  localparam logic [4:0] PORT_A_DIRECTION = 5'h01;
  localparam logic [4:0] PORT_A_OPTION = 5'h02;
  localparam logic [4:0] PORT_B_DATA = 5'h03;
  localparam logic [4:0] PORT_B_DIRECTION = 5'h04;
  localparam logic [4:0] PORT_B_OPTION = 5'h05;
  localparam logic [4:0] PORT_C_DATA = 5'h06;
  localparam logic [4:0] PORT_C_DIRECTION = 5'h07;
  localparam logic [4:0] PORT_C_OPTION = 5'h08;
  localparam logic [4:0] PORT_D_DATA = 5'h09;
  localparam logic [4:0] PORT_D_DIRECTION = 5'h0a;
  localparam logic [4:0] PORT_D_OPTION = 5'h0b;
  localparam logic [4:0] PORT_E_DATA = 5'h0c;
  localparam logic [4:0] PORT_E_DIRECTION = 5'h0d;
  localparam logic [4:0] PORT_E_OPTION = 5'h0e;
  localparam logic [4:0] PORT_F_DATA = 5'h0f;
  localparam logic [4:0] PORT_F_DIRECTION = 5'h10;
  localparam logic [4:0] PORT_F_OPTION = 5'h11;
  localparam logic [4:0] REG_LAST = 5'h11;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam int PORT_A_LINE_THREE = 3;
  localparam int PORT_B_LINE_THREE = 11;
  localparam int PORT_A_HIGH_SINK_LO = 6;
  localparam int PORT_A_HIGH_SINK_HI = 7;
  localparam int PIOPB_PINS = 48;
  // Software register access
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } piopb_bus_t;
  // Per-pin mode decoded from direction and option
  typedef enum logic [2:0] {
    PIOPB_IN_FLOAT,
    PIOPB_IN_PULLUP,
    PIOPB_IN_INT,
    PIOPB_OUT_OPEN_DRAIN,
    PIOPB_OUT_PUSH_PULL,
    PIOPB_OUT_TRUE_OD
  } piopb_mode_t;
endpackage

// *** rtl/piopb_regfile.sv ***
// Register memory holding the 18 port bytes, all bytes brought out on one flat output.
// Assumes single-cycle strobes from the CPU register port.
`timescale 1ns/100ps
module piopb_regfile
  import piopb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic [4:0] i_waddr,
  input wire logic [7:0] i_wdata,
  output logic [PIOPB_PORTS*3*8-1:0] o_flat
);
  logic [7:0] mem [0:17];
  // All port registers clear to zero
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      for (int k = 0; k < 18; k++)
        mem[k] <= PORT_RESET;
    end
    else if (i_wr && i_waddr <= REG_LAST)
      mem[i_waddr] <= i_wdata;
  end
  always_comb
  begin
    for (int k = 0; k < 18; k++)
      o_flat[k*8 +: 8] = mem[k];
  end
endmodule

// *** rtl/piopb_top.sv ***
// Six 8-bit bidirectional ports with data, direction and option registers.
// Assumes pins sampled from outside, peripherals on i_mclk, CPU port one-cycle read data.
// How it works
// - Direction one drives the pin from the data latch.
// - Output pins read back the latch, not the pin, unless a peripheral output drives them.
// - Option selects open-drain at zero, push-pull at one.
// - Latch zero drives low; latch one drives high or floats.
// - Enabled peripheral takes the pin over direction and option.
// - Peripheral output forces output mode with peripheral's drive type.
// - Peripheral inputs need input mode; pin stays readable.
// - Input pin driven by peripheral reads the peripheral output.
// - Output pin feeding peripheral input gives it the latch value.
// - Low-power modes leave ports alone; pin interrupts wake.
// - Interrupt only in interrupt mode and unmasked; no event flag.
// - Pull-up only in pull-up input, high driver only push-pull.
// - Option one gives pull-up or floating interrupt; high-sink pair special.
// - Three consecutive bytes per port, all reset to zero.
// - Input mode reads the pin; writes only change the latch.
// - Qualified interrupt pins per group are ORed into one request.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module piopb_top
  import piopb_pkg::*;
#(
  parameter int NUM_GROUPS = 2
)
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [PIOPB_PINS-1:0] i_pin,
  output logic [PIOPB_PINS-1:0] o_pin,
  output logic [PIOPB_PINS-1:0] o_pin_oe,
  output logic [PIOPB_PINS-1:0] o_pullup_en,
  input wire logic [PIOPB_PINS-1:0] i_alt_out_en,
  input wire logic [PIOPB_PINS-1:0] i_alt_out,
  input wire logic [PIOPB_PINS-1:0] i_alt_push_pull,
  output logic [PIOPB_PINS-1:0] o_alt_in,
  input wire logic [PIOPB_PINS-1:0] i_int_group_a,
  input wire logic [NUM_GROUPS-1:0] i_edge_mode,
  input wire logic [NUM_GROUPS-1:0] i_vector_fetch,
  input wire logic i_int_masked,
  output logic [NUM_GROUPS-1:0] o_int_req
);
  piopb_bus_t bus;
  logic [PIOPB_PORTS*3*8-1:0] flat;
  logic [PIOPB_PINS-1:0] latch;
  logic [PIOPB_PINS-1:0] dir;
  logic [PIOPB_PINS-1:0] opt;
  logic [PIOPB_PINS-1:0] sync1;
  logic [PIOPB_PINS-1:0] sync2;
  logic [PIOPB_PINS-1:0] sync3;
  logic [PIOPB_PINS-1:0] pin_level;
  logic [PIOPB_PINS-1:0] int_pin;
  logic [PIOPB_PINS-1:0] next_pin;
  logic [PIOPB_PINS-1:0] next_oe;
  logic [PIOPB_PINS-1:0] next_pullup;
  logic [PIOPB_PINS-1:0] next_alt_in;
  logic [PIOPB_PINS-1:0] readback;
  logic [PIOPB_PINS-1:0] int_active;
  logic [PIOPB_PINS-1:0] int_active_d;
  logic [NUM_GROUPS-1:0] next_req;
  piopb_mode_t pin_mode [PIOPB_PINS];

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  piopb_regfile u_regs (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_wr(bus.wr),
    .i_waddr(bus.addr),
    .i_wdata(bus.wdata),
    .o_flat(flat)
  );

  // Interrupt-capable lines
  function automatic logic is_int_line(input int n);
    return (n == PORT_A_LINE_THREE) || (n == PORT_B_LINE_THREE);
  endfunction

  // True open-drain high-sink lines
  function automatic logic is_high_sink(input int n);
    return (n == PORT_A_HIGH_SINK_LO) || (n == PORT_A_HIGH_SINK_HI);
  endfunction

  // Unpack registers per port
  always_comb
  begin
    for (int p = 0; p < PIOPB_PORTS; p++)
    begin
      latch[p*8 +: 8] = flat[(p*3)*8 +: 8];
      dir[p*8 +: 8] = flat[(p*3+1)*8 +: 8];
      opt[p*8 +: 8] = flat[(p*3+2)*8 +: 8];
    end
  end

  // Three-stage pin synchroniser, accept when stages two and three agree
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_level <= '0;
    end
    else
    begin
      sync1 <= i_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int n = 0; n < PIOPB_PINS; n++)
        if (sync2[n] == sync3[n])
          pin_level[n] <= sync3[n];
    end
  end

  // Mode decode
  always_comb
  begin
    for (int n = 0; n < PIOPB_PINS; n++)
    begin
      if (!dir[n])
      begin
        if (!opt[n] || is_high_sink(n))
          pin_mode[n] = PIOPB_IN_FLOAT;
        else if (is_int_line(n))
          pin_mode[n] = PIOPB_IN_INT;
        else
          pin_mode[n] = PIOPB_IN_PULLUP;
      end
      else if (is_high_sink(n))
        pin_mode[n] = PIOPB_OUT_TRUE_OD;
      else if (opt[n])
        pin_mode[n] = PIOPB_OUT_PUSH_PULL;
      else
        pin_mode[n] = PIOPB_OUT_OPEN_DRAIN;
    end
  end

  // Pad drive, pull-up, peripheral input and readback
  always_comb
  begin
    for (int n = 0; n < PIOPB_PINS; n++)
    begin
      next_pin[n] = 1'b0;
      next_oe[n] = 1'b0;
      next_pullup[n] = 1'b0;
      if (i_alt_out_en[n])
      begin
        next_pin[n] = i_alt_out[n];
        next_oe[n] = (i_alt_push_pull[n] && !is_high_sink(n)) || !i_alt_out[n];
      end
      else
      begin
        unique case (pin_mode[n])
          PIOPB_OUT_PUSH_PULL:
          begin
            next_pin[n] = latch[n];
            next_oe[n] = 1'b1;
          end
          PIOPB_OUT_OPEN_DRAIN, PIOPB_OUT_TRUE_OD:
          begin
            next_pin[n] = 1'b0;
            next_oe[n] = !latch[n];
          end
          PIOPB_IN_PULLUP:
            next_pullup[n] = 1'b1;
          PIOPB_IN_FLOAT, PIOPB_IN_INT:
            next_oe[n] = 1'b0;
        endcase
      end
      next_alt_in[n] = dir[n] ? latch[n] : pin_level[n];
      if (dir[n] && !i_alt_out_en[n])
        readback[n] = latch[n];
      else if (!dir[n] && i_alt_out_en[n])
        readback[n] = i_alt_out[n];
      else
        readback[n] = pin_level[n];
      int_pin[n] = (pin_mode[n] == PIOPB_IN_INT) && !i_alt_out_en[n];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_pin <= '0;
      o_pin_oe <= '0;
      o_pullup_en <= '0;
      o_alt_in <= '0;
    end
    else
    begin
      o_pin <= next_pin;
      o_pin_oe <= next_oe;
      o_pullup_en <= next_pullup;
      o_alt_in <= next_alt_in;
    end
  end

  // Register read, data registers show readback
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (bus.rd)
    begin
      if (bus.addr > REG_LAST)
        o_rdata <= 8'h00;
      else if (bus.addr % 3 == 0)
        o_rdata <= readback[(bus.addr/3)*8 +: 8];
      else
        o_rdata <= flat[bus.addr*8 +: 8];
    end
  end

  // Active-low interrupt level on a qualified pin; mode low-power independent
  always_comb
  begin
    for (int n = 0; n < PIOPB_PINS; n++)
      int_active[n] = int_pin[n] && !pin_level[n];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      int_active_d <= '0;
    else
      int_active_d <= int_active;
  end

  // Per-group OR and request latch
  always_comb
  begin
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      next_req[g] = o_int_req[g] && !i_vector_fetch[g];
      for (int n = 0; n < PIOPB_PINS; n++)
        if ((i_int_group_a[n] ? 0 : 1) == g)
        begin
          if (!i_int_masked && (i_edge_mode[g] ? (int_active[n] && !int_active_d[n]) : int_active[n]))
            next_req[g] = 1'b1;
        end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      o_int_req <= '0;
    else
      o_int_req <= next_req;
  end

  chk_push_pull_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
    (pin_mode[20] == PIOPB_OUT_PUSH_PULL && !i_alt_out_en[20]) |=> (o_pin[20] == $past(latch[20]) && o_pin_oe[20]))
    else $error("push-pull pin not driven from latch");
  chk_open_drain_float: assert property (@(posedge i_mclk) disable iff (i_reset)
    (pin_mode[16] == PIOPB_OUT_OPEN_DRAIN && latch[16] && !i_alt_out_en[16]) |=> !o_pin_oe[16])
    else $error("open-drain one is driven");
  chk_od_low_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
    (pin_mode[17] == PIOPB_OUT_OPEN_DRAIN && !latch[17] && !i_alt_out_en[17]) |=> (o_pin_oe[17] && !o_pin[17]))
    else $error("open-drain zero not driven low");
  chk_pp_select: assert property (@(posedge i_mclk) disable iff (i_reset)
    (dir[20] && opt[20]) |-> pin_mode[20] == PIOPB_OUT_PUSH_PULL)
    else $error("option one is not push-pull");
  chk_od_select: assert property (@(posedge i_mclk) disable iff (i_reset)
    (dir[16] && !opt[16]) |-> pin_mode[16] == PIOPB_OUT_OPEN_DRAIN)
    else $error("option zero is not open-drain");
  chk_alt_od_release: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_alt_out_en[9] && !i_alt_push_pull[9] && i_alt_out[9]) |=> !o_pin_oe[9])
    else $error("peripheral open-drain one is driven");
  chk_alt_pp_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_alt_out_en[8] && i_alt_push_pull[8]) |=> o_pin_oe[8])
    else $error("peripheral push-pull not driven");
  chk_alt_readback: assert property (@(posedge i_mclk) disable iff (i_reset)
    (bus.rd && bus.addr == PORT_B_DATA && !dir[8] && i_alt_out_en[8]) |=> o_rdata[0] == $past(i_alt_out[8]))
    else $error("input pin did not read peripheral output");
  chk_in_readback: assert property (@(posedge i_mclk) disable iff (i_reset)
    (bus.rd && bus.addr == PORT_D_DATA && !dir[24] && !i_alt_out_en[24]) |=> o_rdata[0] == $past(pin_level[24]))
    else $error("input pin did not read pin level");
  chk_alt_in_pin: assert property (@(posedge i_mclk) disable iff (i_reset)
    !dir[24] |=> o_alt_in[24] == $past(pin_level[24]))
    else $error("peripheral input not pin level");
  chk_input_no_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!dir[25] && !i_alt_out_en[25]) |=> !o_pin_oe[25])
    else $error("input pin driven");
  chk_high_sink_float: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!dir[6] && !i_alt_out_en[6]) |=> !o_pullup_en[6])
    else $error("high-sink pin pulled up");
  chk_int_line_float: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!dir[3] && opt[3]) |=> !o_pullup_en[3])
    else $error("interrupt line pulled up");
  chk_reg_write: assert property (@(posedge i_mclk) disable iff (i_reset)
    (bus.wr && bus.addr == PORT_C_OPTION) |=> opt[23:16] == $past(bus.wdata))
    else $error("option write lost");
  chk_read_map: assert property (@(posedge i_mclk) disable iff (i_reset)
    (bus.rd && bus.addr == PORT_E_OPTION) |=> o_rdata == $past(opt[39:32]))
    else $error("option read wrong");
  chk_bad_addr: assert property (@(posedge i_mclk) disable iff (i_reset)
    (bus.rd && bus.addr > REG_LAST) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pending_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
    (o_int_req[0] && !i_vector_fetch[0]) |=> o_int_req[0])
    else $error("pending request lost");
  chk_group_or: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_int_masked && !i_edge_mode[0] && i_int_group_a[3] && int_active[3]) |=> o_int_req[0])
    else $error("qualified pin raised no request");
  chk_reset_regs: assert property (@(posedge i_mclk)
    (!i_reset && $past(i_reset)) |-> (latch == '0 && dir == '0 && opt == '0 && o_int_req == '0))
    else $error("register not clear after reset");
  chk_pullup_only: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_pullup_en[2] |-> $past(pin_mode[2] == PIOPB_IN_PULLUP && !i_alt_out_en[2]))
    else $error("pull-up outside pull-up mode");
  chk_alt_override: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_alt_out_en[8] |=> (o_pin[8] == $past(i_alt_out[8])))
    else $error("peripheral did not take pin");
  chk_out_readback: assert property (@(posedge i_mclk) disable iff (i_reset)
    (bus.rd && bus.addr == PORT_C_DATA && dir[16] && !i_alt_out_en[16]) |=> o_rdata[0] == $past(latch[16]))
    else $error("output readback not latch");
  chk_alt_in_latch: assert property (@(posedge i_mclk) disable iff (i_reset)
    dir[20] |=> o_alt_in[20] == $past(latch[20]))
    else $error("peripheral input not latch");
  chk_masked_no_req: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_int_masked && !o_int_req[0]) |=> !o_int_req[0])
    else $error("request while masked");
  chk_fetch_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_vector_fetch[0] && i_int_masked) |=> !o_int_req[0])
    else $error("request survived vector fetch");
  chk_reset_float: assert property (@(posedge i_mclk)
    (!i_reset && $past(i_reset)) |-> (o_pin_oe == '0 && o_pullup_en == '0))
    else $error("pin driven after reset");
  cov_int_req: cover property (@(posedge i_mclk) disable iff (i_reset) o_int_req[0]);
  cov_alt_out: cover property (@(posedge i_mclk) disable iff (i_reset) i_alt_out_en[8] && !dir[8]);
  cov_pp_high: cover property (@(posedge i_mclk) disable iff (i_reset) o_pin_oe[8] && o_pin[8]);
  cov_edge_req: cover property (@(posedge i_mclk) disable iff (i_reset) i_edge_mode[0] && o_int_req[0]);
  cov_alt_od: cover property (@(posedge i_mclk) disable iff (i_reset) i_alt_out_en[9] && !i_alt_push_pull[9]);
endmodule

// *** sim/piopb_pins_model.sv ***
// External pin model: pad drive, pull-up and an outside driver resolved to levels.
// Assumes the bench gives the outside driver's enable and value per pin.
`timescale 1ns/100ps
module piopb_pins_model
  import piopb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [PIOPB_PINS-1:0] i_drive,
  input wire logic [PIOPB_PINS-1:0] i_drive_oe,
  input wire logic [PIOPB_PINS-1:0] i_pullup_en,
  input wire logic [PIOPB_PINS-1:0] i_ext_en,
  input wire logic [PIOPB_PINS-1:0] i_ext_val,
  output logic [PIOPB_PINS-1:0] o_level
);
  logic [PIOPB_PINS-1:0] wander = 48'h5555_5555_5555;
  // Undriven pins change every cycle
  always @(posedge i_mclk)
    wander <= ~wander;
  // Pad drive wins, then outside driver, then pull-up
  assign o_level = (i_drive_oe & i_drive)
    | (~i_drive_oe & i_ext_en & i_ext_val)
    | (~i_drive_oe & ~i_ext_en & i_pullup_en)
    | (~i_drive_oe & ~i_ext_en & ~i_pullup_en & wander);
endmodule

// *** sim/piopb_top_tb.sv ***
// Bench for the port bank: register port tasks and pin checks.
// Assumes the pin model on the pad side, peripherals driven by the bench.
`timescale 1ns/100ps
module piopb_top_tb;
  import piopb_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic masked = 1'b1;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [7:0] d;
  logic [47:0] lvl, o_pin, o_pin_oe, o_pullup_en, o_alt_in;
  logic [47:0] alt_en = 48'h0, alt_val = 48'h0, alt_pp = 48'h0, grp = 48'hff;
  logic [47:0] ext_en = 48'hffff_ffff_ffff, ext_val = 48'h0;
  logic [1:0] edge_m = 2'h0, fetch = 2'h0, o_int_req;
  int errors = 0;
  int n_compared = 0;
  int k;

  piopb_top uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(lvl), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_pullup_en(o_pullup_en), .i_alt_out_en(alt_en), .i_alt_out(alt_val), .i_alt_push_pull(alt_pp),
    .o_alt_in(o_alt_in), .i_int_group_a(grp), .i_edge_mode(edge_m), .i_vector_fetch(fetch),
    .i_int_masked(masked), .o_int_req(o_int_req));
  piopb_pins_model pins (.i_mclk(i_mclk), .i_drive(o_pin), .i_drive_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(lvl));

  initial
  begin
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    chk(nm, e, d);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  initial
  begin
    repeat (12) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int a = 0; a < 19; a++)
      rchk("reg_reset", 5'(a), 8'h00);
    for (int p = 0; p < 6; p++)
      chk("oe_pullup_reset", 8'h00, o_pin_oe[p*8+:8] | o_pullup_en[p*8+:8]);
    $display("test reset done");
    for (int p = 0; p < 6; p++)
    begin
      wr(5'(3*p+1), 8'(8'h18+p));
      wr(5'(3*p+2), 8'(8'h81+p));
      rchk("direction", 5'(3*p+1), 8'(8'h18+p));
      rchk("option", 5'(3*p+2), 8'(8'h81+p));
      wr(5'(3*p+1), 8'h00);
      wr(5'(3*p+2), 8'h00);
    end
    $display("test map done");
    ext_en[23:16] <= 8'h00;
    wr(5'h06, 8'ha5);
    wr(5'h08, 8'hf0);
    wr(5'h07, 8'hff);
    settle(3);
    chk("oe_c", 8'hfa, o_pin_oe[23:16]);
    chk("pin_c", 8'ha0, o_pin[23:16]);
    chk("pullup_c", 8'h00, o_pullup_en[23:16]);
    chk("alt_in_c", 8'ha5, o_alt_in[23:16]);
    rchk("data_c", 5'h06, 8'ha5);
    wr(5'h06, 8'h5a);
    settle(3);
    chk("oe_c2", 8'hf5, o_pin_oe[23:16]);
    chk("pin_c2", 8'h50, o_pin[23:16]);
    $display("test output done");
    @(posedge i_mclk);
    ext_val[31:24] <= 8'h3c;
    wr(5'h09, 8'hff);
    settle(6);
    rchk("data_d", 5'h09, 8'h3c);
    chk("oe_d", 8'h00, o_pin_oe[31:24]);
    chk("alt_in_d", 8'h3c, o_alt_in[31:24]);
    $display("test input done");
    wr(5'h0e, 8'hff);
    wr(5'h02, 8'hff);
    settle(3);
    chk("pullup_e", 8'hff, o_pullup_en[39:32]);
    chk("pullup_a", 8'h37, o_pullup_en[7:0]);
    $display("test pullup done");
    @(posedge i_mclk);
    alt_en[9:8] <= 2'b11;
    alt_val[9:8] <= 2'b11;
    alt_pp[9:8] <= 2'b01;
    wr(5'h05, 8'h00);
    wr(5'h03, 8'h00);
    wr(5'h04, 8'h02);
    settle(6);
    chk("oe_b", 8'h01, o_pin_oe[15:8]);
    chk("pin_b", 8'h03, o_pin[15:8]);
    rchk("data_b", 5'h03, 8'h01);
    $display("test alternate done");
    settle(6);
    chk("int_masked", 8'h00, {6'h0, o_int_req});
    @(posedge i_mclk);
    ext_val[3] <= 1'b1;
    settle(6);
    @(posedge i_mclk);
    masked <= 1'b0;
    settle(4);
    chk("int_idle", 8'h00, {6'h0, o_int_req});
    @(posedge i_mclk);
    ext_val[3] <= 1'b0;
    for (k = 0; k < 20 && o_int_req[0] !== 1'b1; k++)
    begin
      @(posedge i_mclk);
      #1;
    end
    if (k == 20)
    begin
      $display("[ERR] int_wait expected 1 seen %b", o_int_req[0]);
      errors++;
    end
    else
    begin
      chk("int_set", 8'h01, {6'h0, o_int_req});
      @(posedge i_mclk);
      ext_val[3] <= 1'b1;
      settle(6);
      chk("int_hold", 8'h01, {6'h0, o_int_req});
      @(posedge i_mclk);
      masked <= 1'b1;
      fetch <= 2'b01;
      @(posedge i_mclk);
      fetch <= 2'b00;
      settle(1);
      chk("int_clear", 8'h00, {6'h0, o_int_req});
      @(posedge i_mclk);
      masked <= 1'b0;
      edge_m <= 2'b01;
      ext_val[3] <= 1'b0;
      settle(8);
      chk("int_edge_set", 8'h01, {6'h0, o_int_req});
      @(posedge i_mclk);
      fetch <= 2'b01;
      @(posedge i_mclk);
      fetch <= 2'b00;
      settle(4);
      chk("int_edge_once", 8'h00, {6'h0, o_int_req});
    end
    $display("test interrupt done");
    end_of_test();
  end
endmodule
